// ---- pkg/intc_pkg.sv ----
package intc_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NUM_SRC      = 12;
   localparam int NUM_LVL      = 4;
   localparam int BANK_W       = 6;
   localparam int PC_W         = 16;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   // Clocks per machine cycle, phase of flag sampling, long call length
   localparam int CLK_PER_MC   = 4;
   localparam logic [1:0] PHASE_THREE = 2'h2;
   localparam logic [1:0] PHASE_LAST  = 2'h3;
   localparam int CALL_MC      = 4;
   localparam logic [2:0] CALL_MC_LAST = 3'h3;

   // ----------------------------------------
   // Enable / priority bit positions, main bank
   // ----------------------------------------
   localparam int BIT_EXT_A    = 0;
   localparam int BIT_TIMER_A  = 1;
   localparam int BIT_EXT_B    = 2;
   localparam int BIT_TIMER_B  = 3;
   localparam int BIT_SERIAL   = 4;
   localparam int BIT_BROWNOUT = 5;

   // ----------------------------------------
   // Enable / priority bit positions, extended bank
   // ----------------------------------------
   localparam int BIT_I2C      = 0;
   localparam int BIT_KEYPAD   = 1;
   localparam int BIT_CMP_A    = 2;
   localparam int BIT_CMP_B    = 3;
   localparam int BIT_WATCHDOG = 4;
   localparam int BIT_BRAKE    = 5;

   // ----------------------------------------
   // Source index in ranking order, 0 is first
   // ----------------------------------------
   localparam int SRC_EXT_A    = 0;
   localparam int SRC_BROWNOUT = 1;
   localparam int SRC_WATCHDOG = 2;
   localparam int SRC_TIMER_A  = 3;
   localparam int SRC_I2C      = 4;
   localparam int SRC_EXT_B    = 5;
   localparam int SRC_KEYPAD   = 6;
   localparam int SRC_CMP_A    = 7;
   localparam int SRC_TIMER_B  = 8;
   localparam int SRC_CMP_B    = 9;
   localparam int SRC_SERIAL   = 10;
   localparam int SRC_BRAKE    = 11;

   // ----------------------------------------
   // Vectors
   // ----------------------------------------
   localparam logic [PC_W-1:0] VEC_EXT_A    = 16'h0003;
   localparam logic [PC_W-1:0] VEC_TIMER_A  = 16'h000B;
   localparam logic [PC_W-1:0] VEC_EXT_B    = 16'h0013;
   localparam logic [PC_W-1:0] VEC_TIMER_B  = 16'h001B;
   localparam logic [PC_W-1:0] VEC_SERIAL   = 16'h0023;
   localparam logic [PC_W-1:0] VEC_BROWNOUT = 16'h002B;
   localparam logic [PC_W-1:0] VEC_I2C      = 16'h0033;
   localparam logic [PC_W-1:0] VEC_KEYPAD   = 16'h003B;
   localparam logic [PC_W-1:0] VEC_CMP_B    = 16'h0043;
   localparam logic [PC_W-1:0] VEC_WATCHDOG = 16'h0053;
   localparam logic [PC_W-1:0] VEC_CMP_A    = 16'h0063;
   localparam logic [PC_W-1:0] VEC_BRAKE    = 16'h0073;

   // Sources allowed to wake from power down (watchdog handled apart)
   localparam logic [NUM_SRC-1:0] WAKE_MASK = 12'h2E3;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_CALL
   } call_state_t;

endpackage : intc_pkg

// ---- core/intc_arbiter.sv ----
// Picks the winning source: highest level first, then fixed ranking
module intc_arbiter
   import intc_pkg::*;
(
   // Requests and levels, index in ranking order
   input  wire logic [intc_pkg::NUM_SRC-1:0]   req,
   input  wire logic [2*intc_pkg::NUM_SRC-1:0] lvl,
   // Winner
   output logic                               found,
   output logic [3:0]                          win_idx,
   output logic [1:0]                          win_lvl
);
   import intc_pkg::*;

   // ----------------------------------------
   // Search
   // ----------------------------------------
   // Scan from last rank to first so earlier rank wins ties
   always_comb begin
      found   = 1'b0;
      win_idx = 4'h0;
      win_lvl = 2'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i] && (!found || lvl[2*i +: 2] >= win_lvl)) begin
            found   = 1'b1;
            win_idx = 4'(i);
            win_lvl = lvl[2*i +: 2];
         end
      end
   end
endmodule : intc_arbiter

// ---- core/intc_core.sv ----
// How it works
// - Poll fresh each machine cycle; refused requests are not remembered.
// - Vectoring to a timer routine clears that timer overflow flag.
// - External flags cleared on vectoring only in edge mode; level mode follows pin.
// - Long call pushes the program counter only, not the status word.
// - Vectors: ext0 0003, timer0 000B, ext1 0013, timer1 001B, serial 0023, brownout 002B.
// - Vectors: I2C 0033, keypad 003B, cmp2 0043, watchdog 0053, cmp1 0063, brake 0073.
// - Interrupt exit pops the program counter and ends current service level.
// - Subroutine exit pops the program counter but leaves service level active.
// - Level is high-bank bit over low-bank bit; 00 lowest, 11 highest.
// - Only strictly higher level preempts; level 3 is never preempted.
// - Simultaneous requests of different levels: higher level wins.
// - Equal levels resolved by fixed ranking, external 0 first, brake last.
// - Main enable bits: ext0 0, timer0 1, ext1 2, timer1 3, serial 4, brownout 5.
// - Extended enables: I2C 0, keypad 1, cmp1 2, cmp2 3, watchdog 4, brake 5.
// - Ext0, ext1, brownout, keypad and comparators wake from power down; others not.
// - Watchdog wakes from power down only when clocked from internal RC.
// - External pins sampled at phase three each machine cycle, updating flags.
// - Timer flags set at phase three; polled no earlier than next machine cycle.
// - Long call lasts four machine cycles; five cycles from flag to routine.
// - Not on the last machine cycle of an instruction, vectoring waits.
// - Call only with no equal/higher in service, last cycle, no interrupt exit or enable write.
// - Edge mode sets the flag on high sample then low sample.
// - Global enable cleared blocks every source.
// - Ext0, ext1 (edge mode only; level mode resamples the pin first) and timer request flags can be set by software to make a real request.
module intc_core
   import intc_pkg::*;
(
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   // External pins and their mode
   input  wire logic                        ext_irq_pin_a,
   input  wire logic                        ext_irq_pin_b,
   input  wire logic                        ext_a_edge_mode,
   input  wire logic                        ext_b_edge_mode,
   // Peripheral flags and timer overflow events
   input  wire logic                        timer_a_overflow,
   input  wire logic                        timer_b_overflow,
   input  wire logic                        serial_transmit_flag,
   input  wire logic                        serial_receive_flag,
   input  wire logic                        brownout_flag,
   input  wire logic                        watchdog_irq_flag,
   input  wire logic                        i2c_flag,
   input  wire logic                        keypad_flag,
   input  wire logic                        comparator_a_flag,
   input  wire logic                        comparator_b_flag,
   input  wire logic                        pwm_brake_flag,
   input  wire logic                        watchdog_on_rc,
   // Software flag writes, index in ranking order
   input  wire logic                        flag_wr,
   input  wire logic [intc_pkg::NUM_SRC-1:0] flag_wdata,
   // Enables and priorities
   input  wire logic                        global_enable,
   input  wire logic [intc_pkg::BANK_W-1:0] main_enable_register,
   input  wire logic [intc_pkg::BANK_W-1:0] extended_enable_register,
   input  wire logic [intc_pkg::BANK_W-1:0] priority_low_bank_a,
   input  wire logic [intc_pkg::BANK_W-1:0] priority_high_bank_a,
   input  wire logic [intc_pkg::BANK_W-1:0] priority_low_bank_b,
   input  wire logic [intc_pkg::BANK_W-1:0] priority_high_bank_b,
   // Instruction sequencer status
   input  wire logic                        last_cycle,
   input  wire logic                        interrupt_exit,
   input  wire logic                        subroutine_exit,
   input  wire logic                        enable_write,
   input  wire logic [intc_pkg::PC_W-1:0]   pc,
   input  wire logic [intc_pkg::PC_W-1:0]   stack_top,
   // Outputs to sequencer
   output logic                             call_busy_ff,
   output logic                             push_pc_ff,
   output logic [intc_pkg::PC_W-1:0]        push_data_ff,
   output logic                             load_pc_ff,
   output logic [intc_pkg::PC_W-1:0]        new_pc_ff,
   output logic [intc_pkg::NUM_LVL-1:0]     in_service_ff,
   output logic                             ext0_request_flag_ff,
   output logic                             ext1_request_flag_ff,
   output logic                             timer_a_overflow_flag_ff,
   output logic                             timer_b_overflow_flag_ff,
   output logic                             wakeup_ff
);
   import intc_pkg::*;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [PC_W-1:0] vector_of(input logic [3:0] idx);
      case (int'(idx))
         SRC_EXT_A:    vector_of = VEC_EXT_A;
         SRC_BROWNOUT: vector_of = VEC_BROWNOUT;
         SRC_WATCHDOG: vector_of = VEC_WATCHDOG;
         SRC_TIMER_A:  vector_of = VEC_TIMER_A;
         SRC_I2C:      vector_of = VEC_I2C;
         SRC_EXT_B:    vector_of = VEC_EXT_B;
         SRC_KEYPAD:   vector_of = VEC_KEYPAD;
         SRC_CMP_A:    vector_of = VEC_CMP_A;
         SRC_TIMER_B:  vector_of = VEC_TIMER_B;
         SRC_CMP_B:    vector_of = VEC_CMP_B;
         SRC_SERIAL:   vector_of = VEC_SERIAL;
         default:      vector_of = VEC_BRAKE;
      endcase
   endfunction : vector_of

   // Highest set in-service level, or 0 with none
   function automatic logic [1:0] top_level(input logic [NUM_LVL-1:0] isv);
      top_level = 2'h0;
      for (int i = 0; i < NUM_LVL; i++) begin
         if (isv[i]) begin
            top_level = 2'(i);
         end
      end
   endfunction : top_level

   // ----------------------------------------
   // Machine cycle phase
   // ----------------------------------------
   logic [1:0]  phase_ff;
   logic        sample_en;
   logic        poll_en;
   assign sample_en = (phase_ff == PHASE_THREE);
   assign poll_en   = (phase_ff == PHASE_LAST);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   // ----------------------------------------
   // Call sequencer signals (declared early)
   // ----------------------------------------
   call_state_t state_ff;
   logic [2:0]  mc_cnt_ff;
   logic [3:0]  grant_idx_ff;
   logic        grant;
   logic [3:0]  win_idx;
   logic [1:0]  win_lvl;
   logic        found;

   // ----------------------------------------
   // External pin sampling and flags
   // ----------------------------------------
   logic pin_a_prev_ff;
   logic pin_b_prev_ff;
   logic clr_ext_a;
   logic clr_ext_b;
   logic clr_tmr_a;
   logic clr_tmr_b;
   assign clr_ext_a = grant && win_idx == 4'(SRC_EXT_A) && ext_a_edge_mode;
   assign clr_ext_b = grant && win_idx == 4'(SRC_EXT_B) && ext_b_edge_mode;
   assign clr_tmr_a = grant && win_idx == 4'(SRC_TIMER_A);
   assign clr_tmr_b = grant && win_idx == 4'(SRC_TIMER_B);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_a_prev_ff <= 1'b1;
         pin_b_prev_ff <= 1'b1;
      end else if (sample_en) begin
         pin_a_prev_ff <= ext_irq_pin_a;
         pin_b_prev_ff <= ext_irq_pin_b;
      end
   end

   // external flags: edge set wins over clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ext0_request_flag_ff <= 1'b0;
         ext1_request_flag_ff <= 1'b0;
      end else begin
         if (sample_en && !ext_a_edge_mode) begin
            ext0_request_flag_ff <= !ext_irq_pin_a;
         end else if (sample_en && pin_a_prev_ff && !ext_irq_pin_a) begin
            ext0_request_flag_ff <= 1'b1;
         end else if (flag_wr) begin
            ext0_request_flag_ff <= flag_wdata[SRC_EXT_A];
         end else if (clr_ext_a) begin
            ext0_request_flag_ff <= 1'b0;
         end
         if (sample_en && !ext_b_edge_mode) begin
            ext1_request_flag_ff <= !ext_irq_pin_b;
         end else if (sample_en && pin_b_prev_ff && !ext_irq_pin_b) begin
            ext1_request_flag_ff <= 1'b1;
         end else if (flag_wr) begin
            ext1_request_flag_ff <= flag_wdata[SRC_EXT_B];
         end else if (clr_ext_b) begin
            ext1_request_flag_ff <= 1'b0;
         end
      end
   end

   // timer flags set at phase three; cleared on vectoring
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timer_a_overflow_flag_ff <= 1'b0;
         timer_b_overflow_flag_ff <= 1'b0;
      end else begin
         if (sample_en && timer_a_overflow) begin
            timer_a_overflow_flag_ff <= 1'b1;
         end else if (flag_wr) begin
            timer_a_overflow_flag_ff <= flag_wdata[SRC_TIMER_A];
         end else if (clr_tmr_a) begin
            timer_a_overflow_flag_ff <= 1'b0;
         end
         if (sample_en && timer_b_overflow) begin
            timer_b_overflow_flag_ff <= 1'b1;
         end else if (flag_wr) begin
            timer_b_overflow_flag_ff <= flag_wdata[SRC_TIMER_B];
         end else if (clr_tmr_b) begin
            timer_b_overflow_flag_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Request vector, ranking order
   // ----------------------------------------
   logic [NUM_SRC-1:0]   flags;
   logic [NUM_SRC-1:0]   enab;
   logic [NUM_SRC-1:0]   req;
   logic [NUM_SRC-1:0]   held_ff;
   logic [NUM_SRC-1:0]   poll_req;
   logic [2*NUM_SRC-1:0] lvl;

   // software-owned flags are only read here
   assign flags = {pwm_brake_flag, serial_transmit_flag | serial_receive_flag,
                   comparator_b_flag, timer_b_overflow_flag_ff, comparator_a_flag,
                   keypad_flag, ext1_request_flag_ff, i2c_flag,
                   timer_a_overflow_flag_ff, watchdog_irq_flag, brownout_flag,
                   ext0_request_flag_ff};
   assign enab = {extended_enable_register[BIT_BRAKE], main_enable_register[BIT_SERIAL],
                  extended_enable_register[BIT_CMP_B], main_enable_register[BIT_TIMER_B],
                  extended_enable_register[BIT_CMP_A], extended_enable_register[BIT_KEYPAD],
                  main_enable_register[BIT_EXT_B], extended_enable_register[BIT_I2C],
                  main_enable_register[BIT_TIMER_A], extended_enable_register[BIT_WATCHDOG],
                  main_enable_register[BIT_BROWNOUT], main_enable_register[BIT_EXT_A]};
   assign req = global_enable ? (flags & enab) : '0;

   // request counts only if it stood at previous poll
   // A flag set at phase three waits one machine cycle; a dropped flag is gone at once
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         held_ff <= '0;
      end else if (poll_en) begin
         held_ff <= flags;
      end
   end
   assign poll_req = req & held_ff;

   // level = high bit : low bit, same positions as enables
   assign lvl = {priority_high_bank_b[BIT_BRAKE],    priority_low_bank_b[BIT_BRAKE],
                 priority_high_bank_a[BIT_SERIAL],   priority_low_bank_a[BIT_SERIAL],
                 priority_high_bank_b[BIT_CMP_B],    priority_low_bank_b[BIT_CMP_B],
                 priority_high_bank_a[BIT_TIMER_B],  priority_low_bank_a[BIT_TIMER_B],
                 priority_high_bank_b[BIT_CMP_A],    priority_low_bank_b[BIT_CMP_A],
                 priority_high_bank_b[BIT_KEYPAD],   priority_low_bank_b[BIT_KEYPAD],
                 priority_high_bank_a[BIT_EXT_B],    priority_low_bank_a[BIT_EXT_B],
                 priority_high_bank_b[BIT_I2C],      priority_low_bank_b[BIT_I2C],
                 priority_high_bank_a[BIT_TIMER_A],  priority_low_bank_a[BIT_TIMER_A],
                 priority_high_bank_b[BIT_WATCHDOG], priority_low_bank_b[BIT_WATCHDOG],
                 priority_high_bank_a[BIT_BROWNOUT], priority_low_bank_a[BIT_BROWNOUT],
                 priority_high_bank_a[BIT_EXT_A],    priority_low_bank_a[BIT_EXT_A]};

   intc_arbiter u_arb (
      .req     (poll_req),
      .lvl     (lvl),
      .found   (found),
      .win_idx (win_idx),
      .win_lvl (win_lvl)
   );

   // ----------------------------------------
   // Grant decision
   // ----------------------------------------
   logic higher_than_service;
   // strictly higher than every active level
   assign higher_than_service = (in_service_ff == '0) ||
                                (win_lvl > top_level(in_service_ff));
   // fresh decision at each poll, no memory
   assign grant = poll_en && state_ff == ST_RUN && found && higher_than_service &&
                  last_cycle && !interrupt_exit && !enable_write;

   // ----------------------------------------
   // Long call sequencer
   // ----------------------------------------
   // four machine cycles of call
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_ff     <= ST_RUN;
         mc_cnt_ff    <= 3'h0;
         grant_idx_ff <= 4'h0;
      end else begin
         case (state_ff)
            ST_RUN: begin
               if (grant) begin
                  state_ff     <= ST_CALL;
                  mc_cnt_ff    <= 3'h0;
                  grant_idx_ff <= win_idx;
               end
            end
            ST_CALL: begin
               if (poll_en) begin
                  if (mc_cnt_ff == CALL_MC_LAST) begin
                     state_ff <= ST_RUN;
                  end
                  mc_cnt_ff <= mc_cnt_ff + 3'h1;
               end
            end
            default: state_ff <= ST_RUN;
         endcase
      end
   end

   // Busy flag mirrors the sequencer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         call_busy_ff <= 1'b0;
      end else begin
         call_busy_ff <= (state_ff == ST_CALL && !(poll_en && mc_cnt_ff == CALL_MC_LAST))
                         || grant;
      end
   end

   // push the program counter only; load vector; pop on exits
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         push_pc_ff   <= 1'b0;
         push_data_ff <= '0;
         load_pc_ff   <= 1'b0;
         new_pc_ff    <= '0;
      end else begin
         push_pc_ff <= grant;
         if (grant) begin
            push_data_ff <= pc;
         end
         load_pc_ff <= 1'b0;
         if (state_ff == ST_CALL && poll_en && mc_cnt_ff == CALL_MC_LAST) begin
            load_pc_ff <= 1'b1;
            new_pc_ff  <= vector_of(grant_idx_ff);
         end else if (interrupt_exit || subroutine_exit) begin
            load_pc_ff <= 1'b1;
            new_pc_ff  <= stack_top;
         end
      end
   end

   // ----------------------------------------
   // In-service levels
   // ----------------------------------------
   // set on grant, clear highest on interrupt exit; plain exit leaves it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         in_service_ff <= '0;
      end else if (grant) begin
         in_service_ff[win_lvl] <= 1'b1;
      end else if (interrupt_exit && in_service_ff != '0) begin
         in_service_ff[top_level(in_service_ff)] <= 1'b0;
      end
   end

   // ----------------------------------------
   // Power down wake-up
   // ----------------------------------------
   logic [NUM_SRC-1:0] wake_mask;
   // wake sources, watchdog only on RC clock
   assign wake_mask = WAKE_MASK | (NUM_SRC'(watchdog_on_rc) << SRC_WATCHDOG);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wakeup_ff <= 1'b0;
      end else begin
         wakeup_ff <= |(req & wake_mask);
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_call_len;
      @(posedge clock) disable iff (!rst_n)
      $rose(push_pc_ff) |-> ##[13:16] load_pc_ff;
   endproperty
   a_call_len: assert property (p_call_len) else $error("call length wrong");

   property p_timer_clear;
      @(posedge clock) disable iff (!rst_n)
      clr_tmr_a && !(sample_en && timer_a_overflow) && !flag_wr
      |=> !timer_a_overflow_flag_ff;
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("timer flag kept");

   property p_no_preempt_top;
      @(posedge clock) disable iff (!rst_n)
      in_service_ff[3] |-> !grant;
   endproperty
   a_no_preempt_top: assert property (p_no_preempt_top) else $error("level3 preempted");

   property p_gate;
      @(posedge clock) disable iff (!rst_n)
      !global_enable |-> !grant;
   endproperty
   a_gate: assert property (p_gate) else $error("grant while disabled");

   property p_last;
      @(posedge clock) disable iff (!rst_n)
      grant |-> last_cycle && !interrupt_exit && !enable_write;
   endproperty
   a_last: assert property (p_last) else $error("grant not allowed");

   property p_isv_set;
      @(posedge clock) disable iff (!rst_n)
      grant |=> in_service_ff[$past(win_lvl)];
   endproperty
   a_isv_set: assert property (p_isv_set) else $error("level not marked");

   property p_ret_keeps;
      @(posedge clock) disable iff (!rst_n)
      subroutine_exit && !interrupt_exit && !grant |=> in_service_ff == $past(in_service_ff);
   endproperty
   a_ret_keeps: assert property (p_ret_keeps) else $error("plain exit released");

   property p_vec_ext;
      @(posedge clock) disable iff (!rst_n)
      grant && win_idx == 4'(SRC_EXT_A) |-> ##17 (load_pc_ff && new_pc_ff == VEC_EXT_A);
   endproperty
   a_vec_ext: assert property (p_vec_ext) else $error("bad vector");

   c_grant:   cover property (@(posedge clock) disable iff (!rst_n) grant);
   c_nest:    cover property (@(posedge clock) disable iff (!rst_n) grant && in_service_ff != '0);
   c_wake:    cover property (@(posedge clock) disable iff (!rst_n) wakeup_ff);
endmodule : intc_core

// ---- bench/seq_model.sv ----
// Sequencer stand-in: a running program counter and one return address
module seq_model
   import intc_pkg::*;
#(
   parameter logic [15:0] STACK_VAL = 16'h1234
)
(
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            rst_n,
   // Sequencer status
   input  wire logic            hold_mid,
   output logic                 last_cycle,
   output logic [PC_W-1:0]      pc,
   output logic [PC_W-1:0]      stack_top
);
   timeunit 1ns;
   timeprecision 1ps;
   // Program counter moves every clock
   always @(posedge clock) begin
      pc <= rst_n ? pc + 16'h0001 : 16'h0100;
   end
   assign last_cycle = !hold_mid;
   assign stack_top  = STACK_VAL;
endmodule : seq_model

// ---- bench/four_level_interrupt_controller_tb.sv ----
module four_level_interrupt_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import intc_pkg::*;
   localparam logic [15:0] STK = 16'h1234;
   // Wake set by rank: ext0, brownout, watchdog on RC, ext1, keypad, both comparators
   localparam logic [11:0] WAKES = 12'h2E7;
   logic clock = 0, rst_n = 0, flag_wr = 0, global_enable = 1, hold_mid = 0;
   logic interrupt_exit = 0, subroutine_exit = 0, pin_hi = 1, low = 0;
   logic rc = 1, pin_a = 1, mode_a = 1;
   logic [11:0] src = 0, flag_wdata = 0, en = 0, plo = 0, phi = 0;
   logic call_busy_ff, push_pc_ff, load_pc_ff, wakeup_ff, last_cycle;
   logic [15:0] push_data_ff, new_pc_ff, pc, stack_top;
   logic [3:0] in_service_ff, hw;
   int error_cnt = 0, comparisons = 0;
   int ebit[12] = '{0, 5, 10, 1, 6, 2, 7, 8, 3, 9, 4, 11};
   logic [15:0] vec[12] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033, 16'h0013,
      16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};
   intc_core dut (.clock, .rst_n, .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_hi),
      .ext_a_edge_mode(mode_a), .ext_b_edge_mode(pin_hi), .timer_a_overflow(low),
      .timer_b_overflow(low), .serial_transmit_flag(low), .serial_receive_flag(src[10]),
      .brownout_flag(src[1]), .watchdog_irq_flag(src[2]), .i2c_flag(src[4]),
      .keypad_flag(src[6]), .comparator_a_flag(src[7]), .comparator_b_flag(src[9]),
      .pwm_brake_flag(src[11]), .watchdog_on_rc(rc), .flag_wr, .flag_wdata,
      .global_enable, .main_enable_register(en[5:0]), .extended_enable_register(en[11:6]),
      .priority_low_bank_a(plo[5:0]), .priority_high_bank_a(phi[5:0]),
      .priority_low_bank_b(plo[11:6]), .priority_high_bank_b(phi[11:6]), .last_cycle,
      .interrupt_exit, .subroutine_exit, .enable_write(low), .pc, .stack_top,
      .call_busy_ff, .push_pc_ff, .push_data_ff, .load_pc_ff, .new_pc_ff, .in_service_ff,
      .ext0_request_flag_ff(hw[0]), .ext1_request_flag_ff(hw[1]),
      .timer_a_overflow_flag_ff(hw[2]), .timer_b_overflow_flag_ff(hw[3]), .wakeup_ff);
   seq_model #(.STACK_VAL(STK)) partner (.clock, .rst_n, .hold_mid, .last_cycle, .pc,
      .stack_top);
   initial forever #4 clock = !clock;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic stop_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   // Raise source by index: stored flags by software write, others as levels
   task automatic raise(input logic [11:0] m);
      src = m;
      flag_wdata = m & 12'h129;
      flag_wr = 1;
      @(posedge clock);
      #1 flag_wr = 0;
   endtask : raise
   // Wait for the call: push with busy, then vector load 16 clocks later
   task automatic call_to(input logic [15:0] v);
      int n = 0, t = 0;
      logic got = 0;
      repeat (60) if (!got) begin
         @(posedge clock);
         #1 got = load_pc_ff;
         n++;
         if (push_pc_ff) begin
            t = n;
            chk("push_pc", push_data_ff + 16'h0001, pc);
            chk("busy", call_busy_ff, 1);
         end
      end
      chk("vector", got ? new_pc_ff : 16'hFFFF, v);
      chk("call_len", n - t, 16);
      chk("busy_end", call_busy_ff, 0);
   endtask : call_to
   task automatic none(input logic [15:0] n);
      logic bad = 0;
      repeat (n) begin
         @(posedge clock);
         #1 bad |= load_pc_ff !== 1'b0;
      end
      chk("no_call", bad, 0);
   endtask : none
   // Exit pulse; interrupt_exit when r set, otherwise plain return
   task automatic leave(input logic r);
      interrupt_exit = r;
      subroutine_exit = !r;
      @(posedge clock);
      #1 interrupt_exit = 0;
      subroutine_exit = 0;
      chk("ret_pc", load_pc_ff ? new_pc_ff : 16'h0, STK);
   endtask : leave
   initial begin
      repeat (16) @(posedge clock);
      #1 rst_n = 1;
      chk("rst_svc", in_service_ff, 0);
      for (int i = 0; i < 12; i++) begin
         en = 12'h001 << ebit[i];
         raise(12'h001 << i);
         @(posedge clock);
         #1 chk("wake", wakeup_ff, WAKES[i]);
         rc = 0;
         @(posedge clock);
         #1 chk("wake_rc", wakeup_ff, WAKES[i] && i != 2);
         rc = 1;
         call_to(vec[i]);
         chk("svc", in_service_ff, 1);
         chk("hw_flags", hw, 0);
         src = 0;
         leave(1);
      end
      en = 12'h009;
      {phi[3], plo[3]} = 2'b11;
      raise(12'h101);
      call_to(16'h001B);
      none(40);
      leave(0);
      chk("svc_kept", in_service_ff, 4'h8);
      @(posedge clock);
      #1 leave(1);
      call_to(16'h0003);
      leave(1);
      global_enable = 0;
      raise(12'h001);
      none(40);
      {global_enable, hold_mid} = 2'b11;
      none(40);
      hold_mid = 0;
      call_to(16'h0003);
      leave(1);
      pin_a = 0;
      call_to(16'h0003);
      chk("edge_clr", hw[0], 0);
      leave(1);
      mode_a = 0;
      call_to(16'h0003);
      chk("level_kept", hw[0], 1);
      pin_a = 1;
      leave(1);
      none(20);
      stop_test();
   end
   initial begin
      #40000;
      error_cnt++;
      stop_test();
   end
endmodule : four_level_interrupt_controller_tb
